/* File: fcrs_mstr.sv */
// Purpose: Serial master that writes the reference register
// Assumes: Line idles high between frames
// Notes:   Frames go out on falling clock edges
`timescale 1ns/1ps
`default_nettype none
module fcrs_mstr #(
  parameter int BITC = 16
) (
  input  wire logic clk,
  output var  logic line
);
  initial line = 1'b1;
  function automatic logic [15:0] crc16(input logic [47:0] m);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 5; i >= 0; i--)
    begin
      c ^= {8'h00, m[i*8 +: 8]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic put(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk) line = f[i];
      repeat (BITC - 1) @(negedge clk);
    end
  endtask
  task automatic send(input logic [47:0] m, input logic bad);
    logic [15:0] c;
    c = crc16(m) ^ {15'h0, bad};
    for (int i = 5; i >= 0; i--)
      put(m[i*8 +: 8]);
    put(c[7:0]);
    put(c[15:8]);
  endtask
endmodule // fcrs_mstr
`default_nettype wire

/* File: fcrs_pkg.sv */
// Purpose: Shared constants and types of the frequency reference select
// Assumes: 50 MHz system clock
// Notes:   Settings arrive as one packed struct
`default_nettype none
package fcrs_pkg;
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned BAUD_BPS = 9600;
  localparam int unsigned BIT_CYC  = CLK_HZ / BAUD_BPS;
  // Silent gap closing a frame: 3.5 characters of 10 bits
  localparam int unsigned GAP_BITS = 35;
  localparam int unsigned GAP_CYC  = BIT_CYC * GAP_BITS;
  localparam int unsigned GATE_MS  = 10;
  localparam int unsigned GATE_CYC = CLK_HZ / 1000 * GATE_MS;
  localparam int unsigned RAMP_US  = 10;
  localparam int unsigned RAMP_CYC = CLK_HZ / 1_000_000 * RAMP_US;
  localparam logic [7:0]  GATES_PER_S = 8'(1000 / GATE_MS);

  localparam logic [15:0] FREQ_REF_ADDR  = 16'h2502;
  localparam logic [15:0] FREQ_REF_MAX   = 16'd40000;
  localparam logic [15:0] KEYPAD_REF_DEF = 16'd500;
  localparam logic [7:0]  FUNC_WR_SINGLE = 8'h06;
  localparam logic [3:0]  FRAME_BYTES    = 4'd8;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'ha001;
  localparam logic [15:0] PCT_FULL       = 16'd1000;

  localparam logic [15:0] DU_RPM_LO  = 16'd2;
  localparam logic [15:0] DU_RPM_HI  = 16'd39;
  localparam logic [15:0] DU_USR_LO  = 16'd40;
  localparam logic [15:0] DU_USR_HI  = 16'd9999;
  localparam logic [15:0] DU_USR1_LO = 16'd10001;
  localparam logic [15:0] DU_USR2_LO = 16'd20001;
  localparam logic [15:0] DU_USR3_LO = 16'd30001;
  localparam logic [15:0] DU_USR_TOP = 16'd39999;
  localparam logic [1:0]  DEC_HZ     = 2'd2;

  typedef enum logic [2:0] {
    SRC_KEYPAD, SRC_ANALOG, SRC_UPDOWN, SRC_COMM, SRC_PULSE, SRC_PID
  } fcrs_src_type;
  typedef enum logic [1:0] {
    PF_FREQ, PF_PID_FB, PF_PID_TGT, PF_RESERVED
  } fcrs_pfunc_type;
  typedef enum logic [2:0] {
    DU_HZ, DU_PCT, DU_RPM, DU_USER, DU_INVALID
  } fcrs_unit_type;

  typedef struct packed {
    fcrs_src_type      src_sel;
    fcrs_pfunc_type    pulse_func;
    logic [15:0]       pulse_scale;
    logic [13:0]       pulse_gain;
    logic signed [11:0] pulse_bias;
    logic [7:0]        pulse_filt;
    logic [2:0]        aux_sel;
    logic [2:0]        sec_in_func;
    logic [15:0]       disp_unit;
    logic [7:0]        node_addr;
    logic [15:0]       max_freq;
  } fcrs_cfg_type;

  localparam fcrs_cfg_type CFG_DEFAULT = '{
    src_sel: SRC_KEYPAD, pulse_func: PF_FREQ, pulse_scale: 16'd10000,
    pulse_gain: 14'd1000, pulse_bias: 12'sd0, pulse_filt: 8'd0,
    aux_sel: 3'd0, sec_in_func: 3'd0, disp_unit: 16'd0,
    node_addr: 8'h01, max_freq: 16'd6000};
endpackage
`default_nettype wire

/* File: fcrs_top.sv */
// Purpose: Frequency reference source select with serial register port
// Assumes: RX and pulse pins asynchronous; other inputs on CLOCK
// Notes:   Serial port answers write-single-register to one address
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Source select picks the main reference
// - Default configuration selects keypad source
// - Register 0x2502 holds reference, 0.01 Hz
// - Serial value used only in communication source
// - Default node 1, 9600 baud, 8N1
// - Serve serial register writes over RS485
// - Frames end in CRC16, checked and echoed
// - Pulse reference when source 4, function 0
// - Pulse function routes frequency or PID
// - Pulse scale gives 100 percent frequency
// - Target equals scaled pulse times gain plus bias
// - Measured pulse frequency is low pass filtered
// - First analog master, second auxiliary
// - Auxiliary from second input when both settings 1
// - Display unit setting selects unit, decimals
// - Output frequency ramps to reference on run
module fcrs_top #(
  parameter int unsigned BIT_CYCLES  = fcrs_pkg::BIT_CYC,
  parameter int unsigned GAP_CYCLES  = fcrs_pkg::GAP_CYC,
  parameter int unsigned GATE_CYCLES = fcrs_pkg::GATE_CYC,
  parameter int unsigned RAMP_CYCLES = fcrs_pkg::RAMP_CYC
) (
  input  wire logic                   CLOCK,
  input  wire logic                   RSTN,
  input  wire fcrs_pkg::fcrs_cfg_type CFG,
  input  wire logic                   CFG_LOAD,
  input  wire logic                   CFG_DEFAULT_LOAD,
  input  wire logic [15:0]            KEYPAD_REF,
  input  wire logic                   KEYPAD_LOAD,
  input  wire logic [15:0]            FIRST_ANALOG_INPUT,
  input  wire logic [15:0]            SECOND_ANALOG_INPUT,
  input  wire logic [15:0]            UPDOWN_REF,
  input  wire logic [15:0]            PID_REF,
  input  wire logic                   RUN,
  input  wire logic                   PULSE_TRAIN_INPUT,
  input  wire logic                   RS485_RX,
  output logic                        RS485_TX,
  output logic                        RS485_TX_EN,
  output logic [15:0]                 FREQUENCY_REFERENCE,
  output logic [15:0]                 SPEED_REF,
  output logic [15:0]                 AUX_REF,
  output logic [15:0]                 OUT_FREQ,
  output logic [15:0]                 PULSE_PCT,
  output logic [15:0]                 PID_FEEDBACK,
  output logic [15:0]                 PID_TARGET,
  output fcrs_pkg::fcrs_unit_type     DISP_KIND,
  output logic [1:0]                  DISP_DECIMALS,
  output logic                        FRAME_ERR
);
  import fcrs_pkg::*;

  localparam logic [15:0] BIT_M1  = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] BIT_HLF = 16'(BIT_CYCLES / 2);
  localparam logic [19:0] GAP_M1  = 20'(GAP_CYCLES - 1);
  localparam logic [19:0] GATE_M1 = 20'(GATE_CYCLES - 1);
  localparam logic [15:0] RAMP_M1 = 16'(RAMP_CYCLES - 1);

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    return x;
  endfunction

  function automatic logic [2:0] filt_shift(input logic [7:0] t);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 1; i < 8; i++)
      if (t >= (8'h01 << i))
        s = 3'(i);
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Settings and pin synchronisers
  fcrs_cfg_type cfg_r;
  logic [15:0]  keypad_ref_r;
  logic         rx_s1_r, rx_s2_r, pl_s1_r, pl_s2_r, pl_s3_r;

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      cfg_r        <= CFG_DEFAULT;
      keypad_ref_r <= KEYPAD_REF_DEF;
    end
    else
    begin
      if (CFG_DEFAULT_LOAD)
        cfg_r <= CFG_DEFAULT;
      else if (CFG_LOAD)
        cfg_r <= CFG;
      if (KEYPAD_LOAD)
        keypad_ref_r <= KEYPAD_REF;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
      {rx_s1_r, rx_s2_r, pl_s1_r, pl_s2_r, pl_s3_r} <= 5'h1b;
    else
      {rx_s1_r, rx_s2_r, pl_s1_r, pl_s2_r, pl_s3_r} <=
        {RS485_RX, rx_s1_r, PULSE_TRAIN_INPUT, pl_s1_r, pl_s2_r};
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial receiver, 1 start, 8 data, 1 stop, no parity
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_st_type;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_st_type;
  rx_st_type   rx_st_r;
  tx_st_type   tx_st_r;
  logic [15:0] rx_cnt_r;
  logic [2:0]  rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic        rx_vld_r;
  wire         rx_bit_end = (rx_cnt_r == BIT_M1);
  wire         tx_busy    = (tx_st_r != TX_IDLE);

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      rx_st_r  <= RX_IDLE;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 3'h0;
      rx_sh_r  <= 8'h00;
      rx_vld_r <= 1'b0;
    end
    else
    begin
      rx_vld_r <= 1'b0;
      rx_cnt_r <= rx_cnt_r + 16'h0001;
      case (rx_st_r)
        RX_IDLE:
        begin
          rx_cnt_r <= 16'h0000;
          // Half duplex: own echo is ignored while sending
          if (!rx_s2_r && !tx_busy)
            rx_st_r <= RX_START;
        end
        RX_START:
          if (rx_cnt_r == BIT_HLF)
          begin
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 3'h0;
            rx_st_r  <= rx_s2_r ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_bit_end)
          begin
            rx_cnt_r <= 16'h0000;
            rx_sh_r  <= {rx_s2_r, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == 3'h7)
              rx_st_r <= RX_STOP;
          end
        RX_STOP:
          if (rx_bit_end)
          begin
            rx_st_r  <= RX_IDLE;
            rx_vld_r <= rx_s2_r;
          end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame assembly, CRC check and register write
  logic [7:0]  buf_r [0:7];
  logic [3:0]  nb_r;
  logic        ovf_r;
  logic [15:0] crc_r;
  logic [19:0] gap_r;
  logic [15:0] freq_reference_r;

  wire        frame_end = (gap_r == GAP_M1) && (nb_r != 4'h0);
  wire        crc_ok    = (crc_r == 16'h0000);
  wire [15:0] wr_addr   = {buf_r[2], buf_r[3]};
  wire [15:0] wr_val    = {buf_r[4], buf_r[5]};
  wire        frame_ok  = (nb_r == FRAME_BYTES) && !ovf_r && crc_ok &&
                          (buf_r[0] == cfg_r.node_addr) &&
                          (buf_r[1] == FUNC_WR_SINGLE) &&
                          (wr_addr == FREQ_REF_ADDR);
  wire        in_range  = (wr_val <= FREQ_REF_MAX);
  wire        wr_ok     = frame_end && frame_ok && in_range;

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      nb_r  <= 4'h0;
      ovf_r <= 1'b0;
      crc_r <= CRC_INIT;
      gap_r <= 20'h00000;
    end
    else if (rx_vld_r)
    begin
      gap_r <= 20'h00000;
      crc_r <= crc_step(crc_r, rx_sh_r);
      if (nb_r == FRAME_BYTES)
        ovf_r <= 1'b1;
      else
        nb_r <= nb_r + 4'h1;
    end
    else if (frame_end)
    begin
      nb_r  <= 4'h0;
      ovf_r <= 1'b0;
      crc_r <= CRC_INIT;
    end
    else if (gap_r != GAP_M1)
      gap_r <= gap_r + 20'h00001;
  end

  always_ff @(posedge CLOCK)
  begin
    if (rx_vld_r && nb_r != FRAME_BYTES)
      buf_r[nb_r[2:0]] <= rx_sh_r;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      freq_reference_r <= 16'h0000;
      FRAME_ERR        <= 1'b0;
    end
    else
    begin
      FRAME_ERR <= frame_end && !wr_ok;
      if (wr_ok)
        freq_reference_r <= wr_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter: echoes an accepted write, CRC bytes included
  logic [15:0] tx_cnt_r;
  logic [2:0]  tx_bit_r, tx_idx_r;
  logic [7:0]  tx_sh_r;
  wire         tx_bit_end = (tx_cnt_r == BIT_M1);

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      tx_st_r     <= TX_IDLE;
      tx_cnt_r    <= 16'h0000;
      tx_bit_r    <= 3'h0;
      tx_idx_r    <= 3'h0;
      tx_sh_r     <= 8'h00;
      RS485_TX    <= 1'b1;
      RS485_TX_EN <= 1'b0;
    end
    else
    begin
      tx_cnt_r <= tx_bit_end ? 16'h0000 : tx_cnt_r + 16'h0001;
      case (tx_st_r)
        TX_IDLE:
        begin
          tx_cnt_r <= 16'h0000;
          tx_idx_r <= 3'h0;
          if (wr_ok)
          begin
            tx_st_r     <= TX_START;
            RS485_TX_EN <= 1'b1;
            RS485_TX    <= 1'b0;
          end
        end
        TX_START:
          if (tx_bit_end)
          begin
            tx_st_r  <= TX_DATA;
            tx_bit_r <= 3'h0;
            tx_sh_r  <= buf_r[tx_idx_r];
            RS485_TX <= buf_r[tx_idx_r][0];
          end
        TX_DATA:
          if (tx_bit_end)
          begin
            tx_bit_r <= tx_bit_r + 3'h1;
            tx_sh_r  <= tx_sh_r >> 1;
            RS485_TX <= (tx_bit_r == 3'h7) ? 1'b1 : tx_sh_r[1];
            if (tx_bit_r == 3'h7)
              tx_st_r <= TX_STOP;
          end
        TX_STOP:
          if (tx_bit_end)
          begin
            tx_idx_r    <= tx_idx_r + 3'h1;
            tx_st_r     <= (tx_idx_r == 3'h7) ? TX_IDLE : TX_START;
            RS485_TX    <= (tx_idx_r == 3'h7);
            RS485_TX_EN <= (tx_idx_r != 3'h7);
          end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse input: gated count, filter, scale, gain and bias
  logic [19:0] gate_r;
  logic [15:0] pcnt_r, pct_raw_r;
  logic [23:0] filt_r;
  logic        div_go_r;
  logic [39:0] div_q_r;
  logic [15:0] div_rem_r;
  logic [5:0]  div_n_r;

  wire        gate_tick = (gate_r == GATE_M1);
  wire        pl_edge   = pl_s2_r && !pl_s3_r;
  wire [23:0] hz        = pcnt_r * GATES_PER_S;
  wire signed [24:0] f_diff = $signed({1'b0, hz}) - $signed({1'b0, filt_r});
  wire [24:0] f_sum = {1'b0, filt_r} +
                      25'(f_diff >>> filt_shift(cfg_r.pulse_filt));
  wire [16:0] rem_sh  = {div_rem_r, div_q_r[39]};
  wire        fits    = (rem_sh >= {1'b0, cfg_r.pulse_scale});
  wire [16:0] rem_sub = rem_sh - {1'b0, cfg_r.pulse_scale};
  wire [39:0] q_new   = {div_q_r[38:0], fits};

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      gate_r <= 20'h00000;
      pcnt_r <= 16'h0000;
      filt_r <= 24'h000000;
      div_go_r <= 1'b0;
    end
    else
    begin
      gate_r   <= gate_tick ? 20'h00000 : gate_r + 20'h00001;
      div_go_r <= gate_tick;
      if (gate_tick)
      begin
        pcnt_r <= {15'h0000, pl_edge};
        filt_r <= f_sum[23:0];
      end
      else if (pl_edge && pcnt_r != 16'hffff)
        pcnt_r <= pcnt_r + 16'h0001;
    end
  end

  // Percent in 0.1 % steps: filtered Hz times 100 % over the scale
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      div_q_r   <= 40'h0;
      div_rem_r <= 16'h0000;
      div_n_r   <= 6'h00;
      pct_raw_r <= 16'h0000;
    end
    else if (div_go_r)
    begin
      div_q_r   <= filt_r * PCT_FULL;
      div_rem_r <= 16'h0000;
      div_n_r   <= 6'd40;
    end
    else if (div_n_r != 6'h00)
    begin
      div_q_r   <= q_new;
      div_rem_r <= fits ? rem_sub[15:0] : rem_sh[15:0];
      div_n_r   <= div_n_r - 6'h01;
      if (div_n_r == 6'h01)
        pct_raw_r <= (|q_new[39:16]) ? 16'hffff : q_new[15:0];
    end
  end

  wire [29:0] g_prod = pct_raw_r * cfg_r.pulse_gain;
  wire [29:0] g_div  = g_prod / 30'(PCT_FULL);
  wire signed [31:0] tgt_s = $signed({2'b00, g_div}) +
                             32'(cfg_r.pulse_bias);
  wire [15:0] tgt = (tgt_s < 0) ? 16'h0000 :
                    (tgt_s > $signed({16'h0000, PCT_FULL})) ? PCT_FULL :
                    tgt_s[15:0];
  wire [31:0] pref_prod = PULSE_PCT * cfg_r.max_freq;
  wire [31:0] pref      = pref_prod / {16'h0000, PCT_FULL};

  ////////////////////////////////////////////////////////////////////////
  // Source selection, routing, ramp and display unit
  wire fcrs_src_type   src = cfg_r.src_sel;
  wire fcrs_pfunc_type pf  = cfg_r.pulse_func;
  wire [15:0] pulse_ref = pref[15:0];
  wire [15:0] main_ref =
    (src == SRC_KEYPAD) ? keypad_ref_r :
    (src == SRC_ANALOG) ? FIRST_ANALOG_INPUT :
    (src == SRC_UPDOWN) ? UPDOWN_REF :
    (src == SRC_COMM)   ? freq_reference_r :
    (src == SRC_PULSE && pf == PF_FREQ) ? pulse_ref :
    (src == SRC_PID)    ? PID_REF : 16'h0000;
  wire aux_on = (cfg_r.aux_sel == 3'd1) && (cfg_r.sec_in_func == 3'd1);

  wire [15:0] du = cfg_r.disp_unit;
  wire fcrs_unit_type kind =
    (du == 16'h0000) ? DU_HZ :
    (du == 16'h0001) ? DU_PCT :
    (du >= DU_RPM_LO && du <= DU_RPM_HI) ? DU_RPM :
    (du >= DU_USR_LO && du <= DU_USR_HI) ? DU_USER :
    (du >= DU_USR1_LO && du <= DU_USR_TOP) ? DU_USER : DU_INVALID;
  wire [1:0] decs = (kind == DU_HZ || kind == DU_PCT) ? DEC_HZ :
                    (du >= DU_USR3_LO && du <= DU_USR_TOP) ? 2'd3 :
                    (du >= DU_USR2_LO && du <= DU_USR_TOP) ? 2'd2 :
                    (du >= DU_USR1_LO && du <= DU_USR_TOP) ? 2'd1 : 2'd0;

  logic [15:0] ramp_r;
  wire         ramp_tick = (ramp_r == RAMP_M1);
  wire [15:0]  ramp_goal = RUN ? SPEED_REF : 16'h0000;

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      FREQUENCY_REFERENCE <= 16'h0000;
      SPEED_REF     <= 16'h0000;
      AUX_REF       <= 16'h0000;
      PULSE_PCT     <= 16'h0000;
      PID_FEEDBACK  <= 16'h0000;
      PID_TARGET    <= 16'h0000;
      DISP_KIND     <= DU_HZ;
      DISP_DECIMALS <= DEC_HZ;
      ramp_r        <= 16'h0000;
      OUT_FREQ      <= 16'h0000;
    end
    else
    begin
      FREQUENCY_REFERENCE <= freq_reference_r;
      SPEED_REF     <= main_ref;
      AUX_REF       <= aux_on ? SECOND_ANALOG_INPUT : 16'h0000;
      PULSE_PCT     <= tgt;
      PID_FEEDBACK  <= (pf == PF_PID_FB) ? tgt : 16'h0000;
      PID_TARGET    <= (pf == PF_PID_TGT) ? tgt : 16'h0000;
      DISP_KIND     <= kind;
      DISP_DECIMALS <= decs;
      ramp_r        <= ramp_tick ? 16'h0000 : ramp_r + 16'h0001;
      if (ramp_tick && OUT_FREQ < ramp_goal)
        OUT_FREQ <= OUT_FREQ + 16'h0001;
      else if (ramp_tick && OUT_FREQ > ramp_goal)
        OUT_FREQ <= OUT_FREQ - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  property p_default_keypad;
    $rose(RSTN) |-> (cfg_r.src_sel == SRC_KEYPAD);
  endproperty
  a_default_keypad: assert property (p_default_keypad)
    else $error("source not keypad after reset");

  property p_comm_ref;
    (src == SRC_COMM) |=> (SPEED_REF == $past(freq_reference_r));
  endproperty
  a_comm_ref: assert property (p_comm_ref)
    else $error("serial value not selected");

  property p_reg_range;
    FREQUENCY_REFERENCE <= FREQ_REF_MAX;
  endproperty
  a_reg_range: assert property (p_reg_range)
    else $error("reference above limit");

  property p_bad_crc;
    (frame_end && !crc_ok) |=> $stable(freq_reference_r) ##1 !RS485_TX_EN;
  endproperty
  a_bad_crc: assert property (p_bad_crc)
    else $error("frame with bad CRC acted on");

  sequence s_write;
    wr_ok ##1 (freq_reference_r == $past(wr_val));
  endsequence
  sequence s_tx_start;
    RS485_TX_EN && !RS485_TX;
  endsequence
  property p_write_echo;
    wr_ok |-> s_write and (##1 s_tx_start);
  endproperty
  a_write_echo: assert property (p_write_echo)
    else $error("write not stored or not echoed");

  property p_pulse_route;
    (src == SRC_PULSE && pf != PF_FREQ) |=> (SPEED_REF == 16'h0000);
  endproperty
  a_pulse_route: assert property (p_pulse_route)
    else $error("pulse used as reference in wrong function");

  property p_pid_route;
    (pf == PF_PID_FB) |=> (PID_TARGET == 16'h0000);
  endproperty
  a_pid_route: assert property (p_pid_route)
    else $error("pulse routed to both PID inputs");

  property p_aux;
    !aux_on |=> (AUX_REF == 16'h0000);
  endproperty
  a_aux: assert property (p_aux)
    else $error("auxiliary reference without selection");

  property p_pct_cap;
    PULSE_PCT <= PCT_FULL;
  endproperty
  a_pct_cap: assert property (p_pct_cap)
    else $error("pulse percent above full scale");

  property p_ramp;
    (ramp_tick && OUT_FREQ < ramp_goal) |=>
      (OUT_FREQ == $past(OUT_FREQ) + 16'h0001);
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("output frequency did not step up");

  property p_disp_hz;
    (du == 16'h0000) |=> (DISP_KIND == DU_HZ && DISP_DECIMALS == DEC_HZ);
  endproperty
  a_disp_hz: assert property (p_disp_hz)
    else $error("display unit Hz decoded wrongly");
endmodule // fcrs_top
`default_nettype wire

/* File: tb.sv */
// Purpose: Self-checking bench of the reference select
// Assumes: Shortened serial, gate and ramp counts
// Notes:   Pulse input runs at 5 kHz throughout
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fcrs_pkg::*;
  logic clk = 0, rstn = 0, cl = 0, dl = 0, run = 0, pin = 0;
  fcrs_cfg_type cfg = CFG_DEFAULT;
  logic [15:0] kr = 0, a1 = 0, a2 = 0, ud = 0, pid = 0, fq = 0;
  logic [15:0] fr, sp, ax, of, pp, fb, tg;
  logic [31:0] x = 32'hc178;
  logic [1:0] dd;
  fcrs_unit_type dk;
  wire logic rx, tx, txe, fe;
  int fails = 0, n_checks = 0;
  fcrs_mstr M (.clk(clk), .line(rx));
  fcrs_top #(.BIT_CYCLES(16), .GAP_CYCLES(400), .GATE_CYCLES(1000),
    .RAMP_CYCLES(4)) DUT (.CLOCK(clk), .RSTN(rstn), .CFG(cfg),
    .CFG_LOAD(cl), .CFG_DEFAULT_LOAD(dl), .KEYPAD_REF(kr),
    .KEYPAD_LOAD(cl), .FIRST_ANALOG_INPUT(a1), .SECOND_ANALOG_INPUT(a2),
    .UPDOWN_REF(ud), .PID_REF(pid), .RUN(run), .PULSE_TRAIN_INPUT(pin),
    .RS485_RX(rx), .RS485_TX(tx), .RS485_TX_EN(txe),
    .FREQUENCY_REFERENCE(fr), .SPEED_REF(sp), .AUX_REF(ax),
    .OUT_FREQ(of), .PULSE_PCT(pp), .PID_FEEDBACK(fb), .PID_TARGET(tg),
    .DISP_KIND(dk), .DISP_DECIMALS(dd), .FRAME_ERR(fe));
  initial forever #10 clk = ~clk;
  initial forever
  begin
    repeat (10) @(negedge clk);
    pin = ~pin;
  end
  function automatic logic [15:0] rnd(input int m);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return 16'(x % m);
  endfunction
  function automatic logic [4:0] ek(input logic [15:0] u);
    if (u == 0) return {DU_HZ, 2'd2};
    if (u == 1) return {DU_PCT, 2'd2};
    if (u <= 39) return {DU_RPM, 2'd0};
    if (u <= 9999) return {DU_USER, 2'd0};
    if (u == 10000 || u > 39999) return {DU_INVALID, 2'd0};
    return {DU_USER, 2'(u / 10000)};
  endfunction
  task automatic chk(input logic [15:0] g, e, input string s);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask
  task automatic ld;
    @(negedge clk) cl = 1;
    @(negedge clk) cl = 0;
    repeat (3) @(negedge clk);
  endtask
  // Samples the echo at bit centres, from half a bit into its start bit
  task automatic echo(input logic [63:0] f);
    logic [9:0] w;
    repeat (8) @(negedge clk);
    for (int k = 7; k >= 0; k--)
    begin
      for (int i = 0; i < 10; i++)
      begin
        w[i] = tx;
        repeat (16) @(negedge clk);
      end
      chk({6'h0, w}, {6'h0, 1'b1, f[k*8 +: 8], 1'b0}, "echo");
    end
  endtask
  task automatic frm(input logic [47:0] m, input logic bad, ok);
    logic a;
    logic [15:0] c;
    a = 0;
    M.send(m, bad);
    for (int i = 0; i < 1000 && !a; i++)
    begin
      @(negedge clk);
      a = txe | fe;
    end
    chk({15'h0, txe}, {15'h0, ok}, "reply");
    chk({15'h0, fe}, {15'h0, !ok}, "error");
    if (ok)
    begin
      fq = m[15:0];
      c = M.crc16(m);
      echo({m, c[7:0], c[15:8]});
    end
    repeat (2) @(negedge clk);
    chk(fr, fq, "register");
    repeat (1800) @(negedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    final_report;
  end
  initial
  begin
    logic [15:0] v, e;
    static logic [15:0] uc [12] = '{0, 1, 2, 39, 40, 9999, 10000, 10001,
                             29999, 30001, 39999, 40000};
    repeat (6) @(negedge clk);
    rstn = 1;
    repeat (3) @(negedge clk);
    chk(sp, 16'd500, "default");
    chk(fr, 16'h0, "reg reset");
    $display("test reset done");
    v = rnd(40001);
    frm({16'h0106, 16'h2502, v}, 0, 1);
    chk(sp, 16'd500, "keypad kept");
    frm({16'h0106, 16'h2502, ~v}, 1, 0);
    frm({16'h0206, 16'h2502, v}, 0, 0);
    frm({16'h0106, 16'h2502, 16'd40001}, 0, 0);
    frm({16'h0106, 16'h2502, 16'd40000}, 0, 1);
    $display("test serial done");
    for (int s = 0; s < 6; s++)
    begin
      kr = rnd(40001);
      a1 = rnd(40001);
      ud = rnd(40001);
      pid = rnd(40001);
      cfg.src_sel = fcrs_src_type'(s);
      ld;
      case (s)
        0: e = kr;
        1: e = a1;
        2: e = ud;
        3: e = fq;
        4: e = 16'd3000;
        default: e = pid;
      endcase
      chk(sp, e, "source");
    end
    $display("test source done");
    cfg.src_sel = SRC_PULSE;
    for (int f = 0; f < 3; f++)
    begin
      v = rnd(401) - 16'd200;
      cfg.pulse_func = fcrs_pfunc_type'(f);
      cfg.pulse_gain = 14'(1000 + 200 * f);
      cfg.pulse_bias = v[11:0];
      ld;
      repeat (2500) @(negedge clk);
      e = 16'(500 + 100 * f) + v;
      chk(pp, e, "pulse pct");
      chk(fb, f == 1 ? e : 16'h0, "feedback");
      chk(tg, f == 2 ? e : 16'h0, "target");
      if (f == 0) chk(sp, 16'(e * 6), "pulse ref");
    end
    $display("test pulse done");
    foreach (uc[i])
    begin
      cfg.disp_unit = uc[i];
      ld;
      e = 16'(ek(uc[i]));
      chk(16'(dk), 16'(e[4:2]), "unit");
      if (e[4:2] == DU_HZ || e[4:2] == DU_USER)
        chk(16'(dd), 16'(e[1:0]), "decimals");
    end
    cfg.aux_sel = 3'd1;
    cfg.sec_in_func = 3'd1;
    a2 = rnd(40001);
    ld;
    chk(ax, a2, "aux");
    cfg.sec_in_func = 3'd0;
    ld;
    chk(ax, 16'h0, "aux off");
    $display("test display done");
    cfg.src_sel = SRC_KEYPAD;
    kr = 16'd500;
    ld;
    run = 1;
    repeat (2500) @(negedge clk);
    chk(of, 16'd500, "ramp up");
    run = 0;
    repeat (2500) @(negedge clk);
    chk(of, 16'h0, "ramp down");
    cfg.src_sel = SRC_COMM;
    ld;
    @(negedge clk) dl = 1;
    @(negedge clk) dl = 0;
    repeat (3) @(negedge clk);
    chk(sp, 16'd500, "defaults");
    $display("test run done");
    final_report;
  end
endmodule // tb
`default_nettype wire
